// [logic/socket_event_regs.sv]
`timescale 1ns/100ps
`include "socket_event_consts.svh"

// ----------------------------------------
// Summary of operation
// RQ1: socket register set sits in memory at base from config offset 10h.
// RQ2: event 00h, mask 04h, state 08h, force 0Ch, control 10h, power 20h.
// RQ3: event bits say only that a change happened; state register tells what.
// RQ4: writing 1 clears an event bit; writing 0 leaves it.
// RQ5: writing 1 to a force bit sets the matching event bit.
// RQ6: reset clears events; a still-changed line may set one again.
// RQ7: software clears all events before enabling interrupts.
// RQ8: event bit 3 sets when powered state changes.
// RQ9: event bits 2 and 1 set when detect levels 2 and 1 change.
// RQ10: event bit 0 on rising status edge for cardbus, both edges otherwise.
// RQ11: event and mask bits 31 to 4 read zero, ignore writes.
// RQ12: masks gate only the interrupt; events still set.
// RQ13: interrupt raised only for enabled event classes.
// RQ14: mask bit 3 enables power-cycle interrupt, default blocked.
// RQ15: detect mask field 2:1 at 11 enables, 00 blocks, others reserved.
// RQ16: mask bit 0 enables card status interrupt, default blocked.
// RQ17: event and mask registers reset to zero.
// RQ18: state bits 0..2 follow status and detect lines, ident changes hidden.
// RQ19: state bit 3 shows socket powered, zero by default.
// RQ20: interrupt held while an enabled event bit stays set.
// ----------------------------------------

module socket_event_regs (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_offset,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] base_addr,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_be,
  output logic mem_hit,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  input wire logic card_status_pin,
  input wire logic detect1_pin_b,
  input wire logic detect2_pin_b,
  input wire logic socket_powered_in,
  input wire logic card_is_cardbus,
  input wire logic card_ident_busy,
  output logic status_change_irq
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [31:0] base_reg;
  logic [3:0] events_reg;
  logic [3:0] events_next;
  logic [3:0] enables_reg;
  logic [`SIDE_WIDTH-1:0] control_reg;
  logic [`SIDE_WIDTH-1:0] power_mgmt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  logic [3:0] ev_clear;
  logic [3:0] ev_set;
  logic [3:0] enable_eff;
  logic ev_wr;
  logic force_wr;
  logic enable_wr;
  logic rd_take;
  socket_event_pkg::reg_sel_type sel;

  socket_sense_if sense_bus ();

  // ----------------------------------------
  // line sensing
  // ----------------------------------------
  socket_line_sense u_sense (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .card_status_pin(card_status_pin),
    .detect1_pin_b(detect1_pin_b),
    .detect2_pin_b(detect2_pin_b),
    .socket_powered_in(socket_powered_in),
    .card_is_cardbus(card_is_cardbus),
    .card_ident_busy(card_ident_busy),
    .sense(sense_bus.sense)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------

  // word offset to register; reserved and unlisted offsets map to none
  function automatic socket_event_pkg::reg_sel_type decode_sel(input logic [11:0] ofs);
    logic [11:0] word;
    word = {ofs[11:2], 2'b00};
    case (word)
      `OFS_EVENT: decode_sel = socket_event_pkg::SEL_EVENT;
      `OFS_MASK: decode_sel = socket_event_pkg::SEL_MASK;
      `OFS_STATE: decode_sel = socket_event_pkg::SEL_STATE;
      `OFS_FORCE: decode_sel = socket_event_pkg::SEL_FORCE;
      `OFS_CONTROL: decode_sel = socket_event_pkg::SEL_CONTROL;
      `OFS_POWER_MGMT: decode_sel = socket_event_pkg::SEL_POWER_MGMT;
      default: decode_sel = socket_event_pkg::SEL_NONE;
    endcase
  endfunction : decode_sel

  // claim the cycle when the upper bits match the programmed base
  assign mem_hit = mem_req && ((mem_addr & `BASE_KEEP_MASK) == base_reg); // [RQ1]
  assign sel = decode_sel(mem_addr[11:0]); // [RQ2]

  // only the low byte carries writable bits
  assign ev_wr = mem_hit && mem_we && mem_be[0] && (sel == socket_event_pkg::SEL_EVENT);
  assign enable_wr = mem_hit && mem_we && mem_be[0] && (sel == socket_event_pkg::SEL_MASK);
  assign force_wr = mem_hit && mem_we && mem_be[0] && (sel == socket_event_pkg::SEL_FORCE);
  assign rd_take = mem_hit && !mem_we;

  // ----------------------------------------
  // base address
  // ----------------------------------------

  // low twelve bits stay zero: the window is 4 KB aligned
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      base_reg <= `BASE_RESET;
    end else if (cfg_wr && (cfg_offset == `CFG_BASE_OFFSET)) begin
      base_reg <= cfg_wdata & `BASE_KEEP_MASK; // [RQ1]
    end
  end

  assign base_addr = base_reg;

  // ----------------------------------------
  // event bits
  // ----------------------------------------

  // set wins over a clear in the same cycle so no change is lost
  always_comb begin
    ev_clear = ev_wr ? mem_wdata[3:0] : 4'h0; // [RQ4] [RQ11]
    ev_set = sense_bus.changed; // [RQ8] [RQ9] [RQ10] [RQ12]
    if (force_wr) ev_set = ev_set | mem_wdata[3:0]; // [RQ5]
    events_next = (events_reg & ~ev_clear) | ev_set;
  end

  // bits record only that something changed, never its direction
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      events_reg <= `EVENT_RESET; // [RQ6] [RQ17]
    end else begin
      events_reg <= events_next; // [RQ3]
    end
  end

  // ----------------------------------------
  // interrupt enables
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      enables_reg <= `ENABLE_RESET; // [RQ17]
    end else if (enable_wr) begin
      enables_reg <= mem_wdata[3:0]; // [RQ11]
    end
  end

  // reserved detect codes 01 and 10 are treated as blocking
  always_comb begin
    enable_eff = 4'h0;
    enable_eff[`EV_POWER_BIT] = enables_reg[`EV_POWER_BIT]; // [RQ14]
    enable_eff[`EV_DET2_BIT] = (enables_reg[2:1] == `DETECT_ENABLE_ON); // [RQ15]
    enable_eff[`EV_DET1_BIT] = (enables_reg[2:1] == `DETECT_ENABLE_ON); // [RQ15]
    enable_eff[`EV_STATUS_BIT] = enables_reg[`EV_STATUS_BIT]; // [RQ16]
  end

  // level request; stale events fire the moment enables go up
  assign status_change_irq = |(events_reg & enable_eff); // [RQ13] [RQ20] [RQ7]

  // ----------------------------------------
  // control and power management
  // ----------------------------------------

  // contents defined elsewhere; kept as plain low-byte storage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      control_reg <= `SIDE_RESET;
      power_mgmt_reg <= `SIDE_RESET;
    end else if (mem_hit && mem_we && mem_be[0]) begin
      if (sel == socket_event_pkg::SEL_CONTROL) control_reg <= mem_wdata[7:0];
      if (sel == socket_event_pkg::SEL_POWER_MGMT) power_mgmt_reg <= mem_wdata[7:0];
    end
  end

  // ----------------------------------------
  // read data and acknowledge
  // ----------------------------------------

  // one register slice of read data; force register reads as zero
  function automatic logic [31:0] read_word(
    input socket_event_pkg::reg_sel_type s,
    input logic [3:0] ev,
    input logic [3:0] en,
    input logic [3:0] live,
    input logic [7:0] ctl,
    input logic [7:0] pm
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (s)
      socket_event_pkg::SEL_EVENT: w[3:0] = ev; // [RQ11]
      socket_event_pkg::SEL_MASK: w[3:0] = en; // [RQ11]
      socket_event_pkg::SEL_STATE: begin
        w[3:0] = live; // [RQ18] [RQ19]
        w[`STATE_3V_BIT] = 1'b1;
        w[`STATE_5V_BIT] = 1'b1;
      end
      socket_event_pkg::SEL_CONTROL: w[7:0] = ctl;
      socket_event_pkg::SEL_POWER_MGMT: w[7:0] = pm;
      default: w = 32'h0000_0000;
    endcase
    read_word = w;
  endfunction : read_word

  // every claimed cycle answers one edge later, writes included
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= mem_hit;
      if (rd_take) begin
        rdata_reg <= read_word(sel, events_reg, enables_reg, sense_bus.live_state, control_reg, power_mgmt_reg);
      end
    end
  end

  assign mem_ack = ack_reg;
  assign mem_rdata = rdata_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------

  a_clear_on_one: assert property ( // [RQ4]
    @(posedge sys_clk) disable iff (!rst_b)
    (ev_wr && mem_wdata[0] && !ev_set[0]) |=> !events_reg[0])
    else $error("event bit not cleared by write of one");

  a_zero_keeps: assert property ( // [RQ4]
    @(posedge sys_clk) disable iff (!rst_b)
    (ev_wr && !mem_wdata[1] && events_reg[1]) |=> events_reg[1])
    else $error("event bit lost on write of zero");

  a_force_sets: assert property ( // [RQ5]
    @(posedge sys_clk) disable iff (!rst_b)
    (force_wr && mem_wdata[3]) |=> events_reg[3])
    else $error("forced event did not set");

  a_power_change: assert property ( // [RQ8]
    @(posedge sys_clk) disable iff (!rst_b)
    $changed(sense_bus.live_state[3]) |-> ##[0:1] events_reg[3])
    else $error("power change not recorded");

  a_detect_change: assert property ( // [RQ9]
    @(posedge sys_clk) disable iff (!rst_b)
    (sense_bus.changed[2] && enables_reg == 4'h0) |=> events_reg[2])
    else $error("detect change lost while masked");

  a_status_event: assert property ( // [RQ10]
    @(posedge sys_clk) disable iff (!rst_b)
    sense_bus.changed[0] |=> events_reg[0])
    else $error("status edge not recorded");

  a_upper_zero: assert property ( // [RQ11]
    @(posedge sys_clk) disable iff (!rst_b)
    (rd_take && sel == socket_event_pkg::SEL_MASK) |=> (mem_ack && mem_rdata[31:4] == 28'h0000000))
    else $error("reserved mask bits read nonzero");

  a_reset_clear: assert property ( // [RQ17]
    @(posedge sys_clk) disable iff (!rst_b)
    !$past(rst_b) |-> (events_reg == 4'h0 && enables_reg == 4'h0))
    else $error("registers not zero after reset");

  a_irq_power: assert property ( // [RQ14]
    @(posedge sys_clk) disable iff (!rst_b)
    (events_reg == 4'h8) |-> (status_change_irq == enables_reg[3]))
    else $error("power interrupt gating wrong");

  a_detect_rsvd: assert property ( // [RQ15]
    @(posedge sys_clk) disable iff (!rst_b)
    (events_reg == 4'h2 && enables_reg[2:1] != 2'h3) |-> !status_change_irq)
    else $error("detect interrupt with field not 11");

  a_irq_holds: assert property ( // [RQ20]
    @(posedge sys_clk) disable iff (!rst_b)
    (status_change_irq && !ev_wr && !enable_wr) |=> status_change_irq)
    else $error("interrupt dropped without clear");

  a_state_view: assert property ( // [RQ18]
    @(posedge sys_clk) disable iff (!rst_b)
    (rd_take && sel == socket_event_pkg::SEL_STATE) |=> mem_rdata[3:0] == $past(sense_bus.live_state))
    else $error("state read does not show live lines");

endmodule : socket_event_regs

// [common/socket_event_consts.svh]
`ifndef SOCKET_EVENT_CONSTS_SVH
`define SOCKET_EVENT_CONSTS_SVH

// ----------------------------------------
// configuration space
// ----------------------------------------
`define CFG_BASE_OFFSET 8'h10
`define BASE_KEEP_MASK 32'hffff_f000
`define BASE_RESET 32'h0000_0000

// ----------------------------------------
// socket register offsets
// ----------------------------------------
`define OFS_EVENT 12'h000
`define OFS_MASK 12'h004
`define OFS_STATE 12'h008
`define OFS_FORCE 12'h00c
`define OFS_CONTROL 12'h010
`define OFS_POWER_MGMT 12'h020

// ----------------------------------------
// field positions and resets
// ----------------------------------------
`define EV_WIDTH 4
`define EV_POWER_BIT 3
`define EV_DET2_BIT 2
`define EV_DET1_BIT 1
`define EV_STATUS_BIT 0
`define EVENT_RESET 4'h0
`define ENABLE_RESET 4'h0
`define DETECT_ENABLE_ON 2'h3
`define STATE_3V_BIT 29
`define STATE_5V_BIT 28
`define SIDE_WIDTH 8
`define SIDE_RESET 8'h00
`define SENSE_LINES 3
`define LEVEL_RESET 3'b110

`endif

// [common/socket_event_pkg.sv]
package socket_event_pkg;

  // register selected by a socket-window offset
  typedef enum {
    SEL_EVENT,
    SEL_MASK,
    SEL_STATE,
    SEL_FORCE,
    SEL_CONTROL,
    SEL_POWER_MGMT,
    SEL_NONE
  } reg_sel_type;

endpackage : socket_event_pkg

// [common/socket_sense_if.sv]
`timescale 1ns/100ps

// live socket levels and one-cycle change pulses
interface socket_sense_if;
  logic [3:0] live_state;
  logic [3:0] changed;

  modport sense (
    output live_state,
    output changed
  );

  modport regs (
    input live_state,
    input changed
  );
endinterface : socket_sense_if

// [logic/socket_line_sense.sv]
`timescale 1ns/100ps
`include "socket_event_consts.svh"

module socket_line_sense (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic card_status_pin,
  input wire logic detect1_pin_b,
  input wire logic detect2_pin_b,
  input wire logic socket_powered_in,
  input wire logic card_is_cardbus,
  input wire logic card_ident_busy,
  socket_sense_if.sense sense
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [`SENSE_LINES-1:0] pins;
  logic [`SENSE_LINES-1:0] s1_reg;
  logic [`SENSE_LINES-1:0] s2_reg;
  logic [`SENSE_LINES-1:0] s3_reg;
  logic [`SENSE_LINES-1:0] lvl_reg;
  logic [`SENSE_LINES-1:0] lvl_next;
  logic power_reg;
  logic [3:0] changed_reg;

  // idle pin levels: detect high (no card), status low
  localparam logic [`SENSE_LINES-1:0] level_idle = `LEVEL_RESET;

  assign pins = {detect2_pin_b, detect1_pin_b, card_status_pin};

  // three stages; level accepted once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < `SENSE_LINES; g++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          s1_reg[g] <= level_idle[g];
          s2_reg[g] <= level_idle[g];
          s3_reg[g] <= level_idle[g];
        end else begin
          s1_reg[g] <= pins[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
        end
      end
    end
  endgenerate

  // detect changes are hidden while the card is being identified
  always_comb begin
    lvl_next = lvl_reg;
    if (s2_reg[0] == s3_reg[0]) lvl_next[0] = s3_reg[0]; // [RQ18]
    if (!card_ident_busy) begin // [RQ18]
      if (s2_reg[1] == s3_reg[1]) lvl_next[1] = s3_reg[1];
      if (s2_reg[2] == s3_reg[2]) lvl_next[2] = s3_reg[2];
    end
  end

  // levels reset to no card, no status, powered down; matching the
  // synchroniser reset avoids a false detect change after reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_reg <= level_idle;
      power_reg <= 1'b0;
    end else begin
      lvl_reg <= lvl_next;
      power_reg <= socket_powered_in; // [RQ19]
    end
  end

  // change pulses; a level still differing after reset re-fires
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      changed_reg <= 4'h0;
    end else begin
      changed_reg[`EV_POWER_BIT] <= power_reg != socket_powered_in; // [RQ8]
      changed_reg[`EV_DET2_BIT] <= lvl_reg[2] != lvl_next[2]; // [RQ9]
      changed_reg[`EV_DET1_BIT] <= lvl_reg[1] != lvl_next[1]; // [RQ9]
      changed_reg[`EV_STATUS_BIT] <= card_is_cardbus ? (!lvl_reg[0] && lvl_next[0])
                                                     : (lvl_reg[0] != lvl_next[0]); // [RQ10] [RQ6]
    end
  end

  assign sense.live_state = {power_reg, lvl_reg};
  assign sense.changed = changed_reg;

  a_ident_hides: assert property ( // [RQ18]
    @(posedge sys_clk) disable iff (!rst_b)
    card_ident_busy |=> $stable(lvl_reg[2:1]))
    else $error("detect level moved during identification");

  a_cardbus_no_fall: assert property ( // [RQ10]
    @(posedge sys_clk) disable iff (!rst_b)
    ($fell(lvl_reg[0]) && $past(card_is_cardbus)) |-> !changed_reg[0])
    else $error("falling status edge flagged for cardbus card");

endmodule : socket_line_sense

// [verif/card_socket_model.sv]
`timescale 1ns/100ps

// ----------------------------------------
// card side of the socket
// ----------------------------------------
module card_socket_model (
  input wire logic sys_clk,
  output logic card_status_pin,
  output logic detect1_pin_b,
  output logic detect2_pin_b,
  output logic socket_powered_in,
  output logic card_is_cardbus,
  output logic card_ident_busy
);
  // empty socket, unpowered, until told otherwise
  initial begin
    card_status_pin = 1'b0;
    detect1_pin_b = 1'b1;
    detect2_pin_b = 1'b1;
    socket_powered_in = 1'b0;
    card_is_cardbus = 1'b1;
    card_ident_busy = 1'b0;
  end

  // all lines move at the falling edge, half a period clear of sampling
  task automatic set_lines(input logic st, input logic d1b, input logic d2b, input logic pw,
                           input logic cb, input logic busy);
    @(negedge sys_clk);
    socket_powered_in = pw;
    card_is_cardbus = cb;
    card_ident_busy = busy;
    card_status_pin = st;
    detect1_pin_b = d1b;
    detect2_pin_b = d2b;
  endtask : set_lines
endmodule : card_socket_model

// [verif/tb_top.sv]
`timescale 1ns/100ps

module tb_top;
  logic sys_clk, rst_b, cfg_wr, mem_req, mem_we, mem_hit, mem_ack, status_change_irq;
  logic [7:0] cfg_offset;
  logic [31:0] cfg_wdata, base_addr, mem_addr, mem_wdata, mem_rdata, scratch;
  logic [3:0] mem_be, ev, m, e;
  logic card_status_pin, detect1_pin_b, detect2_pin_b, socket_powered_in, card_is_cardbus, card_ident_busy;
  logic [3:0] masks [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hf};
  int fail_count = 0;
  int cmp_count = 0;

  socket_event_regs u_socket_event_regs (.sys_clk(sys_clk), .rst_b(rst_b), .cfg_wr(cfg_wr),
    .cfg_offset(cfg_offset), .cfg_wdata(cfg_wdata), .base_addr(base_addr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_hit(mem_hit),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .card_status_pin(card_status_pin),
    .detect1_pin_b(detect1_pin_b), .detect2_pin_b(detect2_pin_b), .socket_powered_in(socket_powered_in),
    .card_is_cardbus(card_is_cardbus), .card_ident_busy(card_ident_busy),
    .status_change_irq(status_change_irq));

  card_socket_model u_card_socket_model (.sys_clk(sys_clk), .card_status_pin(card_status_pin),
    .detect1_pin_b(detect1_pin_b), .detect2_pin_b(detect2_pin_b), .socket_powered_in(socket_powered_in),
    .card_is_cardbus(card_is_cardbus), .card_ident_busy(card_ident_busy));

  // ----------------------------------------
  // clock, checks and closing
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic cfg_write(input logic [7:0] ofs, input logic [31:0] d);
    @(negedge sys_clk);
    cfg_wr = 1'b1;
    cfg_offset = ofs;
    cfg_wdata = d;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
  endtask : cfg_write

  // request stands for one edge only; a longer hold would be taken twice
  task automatic acc(input logic we, input logic [11:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
    @(negedge sys_clk);
    mem_req = 1'b1;
    mem_we = we;
    mem_addr = base_addr + {20'h0, ofs};
    mem_wdata = wd;
    mem_be = 4'h1;
    @(negedge sys_clk);
    chk({31'h0, mem_ack}, 32'h1, "ack after hit");
    rd = mem_rdata;
    mem_req = 1'b0;
    mem_addr = ~mem_addr;
    mem_wdata = ~wd;
  endtask : acc

  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    acc(1'b1, ofs, d, scratch);
  endtask : wr

  task automatic rd_chk(input logic [11:0] ofs, input logic [31:0] exp, input string msg);
    logic [31:0] r;
    acc(1'b0, ofs, 32'h0, r);
    chk(r, exp, msg);
  endtask : rd_chk

  // move the card lines, let them cross, then check and clear the events
  task automatic pin_step(input logic [5:0] lines, input logic [31:0] ev_exp, input logic [31:0] st_exp);
    u_card_socket_model.set_lines(lines[5], lines[4], lines[3], lines[2], lines[1], lines[0]);
    repeat (8) @(posedge sys_clk);
    rd_chk(12'h000, ev_exp, "pin event");
    rd_chk(12'h008, st_exp, "live state");
    wr(12'h000, 32'hf);
  endtask : pin_step

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("BAD t=%0t watchdog expired", $time);
    finish_test();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    {cfg_wr, mem_req, mem_we} = 3'h0;
    cfg_offset = 8'h00;
    {cfg_wdata, mem_addr, mem_wdata} = {96{1'b0}};
    mem_be = 4'h0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    rd_chk(12'h000, 32'h0, "event reset");
    rd_chk(12'h004, 32'h0, "mask reset");
    rd_chk(12'h008, 32'h3000_0006, "state reset");
    rd_chk(12'h010, 32'h0, "control reset");
    rd_chk(12'h020, 32'h0, "power reset");
    rd_chk(12'h014, 32'h0, "reserved reads zero");
    $display("test reset_values done");

    cfg_write(8'h10, 32'h1234_5abc);
    cfg_write(8'h14, 32'h0000_0000);
    chk(base_addr, 32'h1234_5000, "base placement");
    @(negedge sys_clk);
    mem_req = 1'b1;
    mem_we = 1'b0;
    mem_addr = 32'h0000_0000;
    #1;
    chk({31'h0, mem_hit}, 32'h0, "old base claimed");
    @(negedge sys_clk);
    chk({31'h0, mem_ack}, 32'h0, "miss acked");
    mem_req = 1'b0;
    wr(12'h010, 32'h5a);
    wr(12'h020, 32'ha5);
    rd_chk(12'h010, 32'h5a, "control offset");
    rd_chk(12'h020, 32'ha5, "power offset");
    wr(12'h004, 32'hffff_ffff);
    rd_chk(12'h004, 32'h0000_000f, "mask upper bits");
    wr(12'h004, 32'h0);
    $display("test decode done");

    // forced events, write-one-to-clear, one bit at a time
    for (int i = 0; i < 4; i++) begin
      wr(12'h00c, 32'h1 << i);
      rd_chk(12'h000, 32'h1 << i, "forced event");
      rd_chk(12'h00c, 32'h0, "force reads zero");
      wr(12'h000, 32'hffff_fff0 | ~(32'h1 << i));
      rd_chk(12'h000, 32'h1 << i, "zero write kept bit");
      wr(12'h000, 32'h1 << i);
      rd_chk(12'h000, 32'h0, "one write cleared");
    end
    $display("test force_clear done");

    // each event class against seven mask codes; events cleared before enabling
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 7; k++) begin
        wr(12'h004, 32'h0);
        wr(12'h000, 32'hf);
        wr(12'h00c, 32'h1 << i);
        wr(12'h004, {28'h0, masks[k]});
        ev = 4'h1 << i;
        m = masks[k];
        e = {m[3], m[2] & m[1], m[2] & m[1], m[0]};
        chk({31'h0, status_change_irq}, {31'h0, |(ev & e)}, "irq gating");
      end
    end
    repeat (3) @(negedge sys_clk);
    chk({31'h0, status_change_irq}, 32'h1, "irq held");
    wr(12'h000, 32'h8);
    chk({31'h0, status_change_irq}, 32'h0, "irq after clear");
    wr(12'h004, 32'h0);
    $display("test irq_mask done");

    // lines: status, det1_b, det2_b, powered, cardbus, ident busy
    pin_step(6'b011110, 32'h8, 32'h3000_000e);
    pin_step(6'b001110, 32'h2, 32'h3000_000c);
    pin_step(6'b000111, 32'h0, 32'h3000_000c);
    pin_step(6'b000110, 32'h4, 32'h3000_0008);
    pin_step(6'b100110, 32'h1, 32'h3000_0009);
    pin_step(6'b000110, 32'h0, 32'h3000_0008);
    pin_step(6'b100100, 32'h1, 32'h3000_0009);
    pin_step(6'b000100, 32'h1, 32'h3000_0008);
    pin_step(6'b011000, 32'he, 32'h3000_0006);
    $display("test card_lines done");

    wr(12'h00c, 32'hf);
    wr(12'h004, 32'hf);
    @(negedge sys_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    rd_chk(12'h000, 32'h0, "event after reset");
    rd_chk(12'h004, 32'h0, "mask after reset");
    chk({31'h0, status_change_irq}, 32'h0, "irq after reset");
    $display("test mid_reset done");
    finish_test();
  end
endmodule : tb_top
